// ### src/rols_pkg.sv
// Constants and types for the rail order logging status block.
// Assumes a command decoder that presents reads and acknowledges as one-cycle pulses.
package rols_pkg;
   localparam int ROLS_CHANNELS = 6;
   localparam logic [7:0] ROLS_SELFTEST_ADDR = 8'h31;
   localparam logic [7:0] ROLS_OFF_ADDR = 8'h32;
   localparam logic [7:0] ROLS_REC_ADDR = 8'h34;
   localparam logic [7:0] ROLS_POWERUP_BASE = 8'h50;
   localparam logic [7:0] ROLS_POWERDOWN_BASE = 8'h60;
   localparam logic [7:0] ROLS_WAKE_BASE = 8'h70;
   localparam logic [7:0] ROLS_DOZE_BASE = 8'h80;
   localparam int ROLS_SELFTEST_BIT = 0;
   localparam int ROLS_ACTIVE_BIT = 7;
   localparam int ROLS_KIND_LSB = 5;
   localparam int ROLS_STAMP_BIT = 4;
   localparam int ROLS_POWERUP_BIT = 3;
   localparam int ROLS_POWERDOWN_BIT = 2;
   localparam int ROLS_WAKE_BIT = 1;
   localparam int ROLS_DOZE_BIT = 0;
   localparam logic [7:0] ROLS_UNMAPPED_DATA = 8'h00;
   localparam logic [7:0] ROLS_ENTRY_RESET = 8'h00;
   localparam logic ROLS_FLAG_RESET = 1'b0;

   typedef enum logic [1:0] {
      rols_powerup,
      rols_powerdown,
      rols_wake,
      rols_doze
   } rols_kind_e;

   typedef struct packed {
      logic stamp;
      logic powerup;
      logic powerdown;
      logic wake;
      logic doze;
   } rols_ack_s;
endpackage

// ### src/rols_status.sv
// Status registers and power order recording of a six channel voltage monitor.
// Assumes the serial command decoder delivers reads and acknowledge writes as pulses.
module rols_status
   import rols_pkg::*;
#(
   parameter int CHANNELS = ROLS_CHANNELS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic shutdown_control_pin,
   input wire logic sleep_control_pin,
   input wire logic manual_log_trigger,
   input wire logic [CHANNELS-1:0] channel_crossed,
   input wire logic [7:0] sync_edge_counter,
   input wire logic [CHANNELS-1:0] channel_off,
   input wire logic analog_selftest_fail,
   input wire logic [CHANNELS-1:0] channel_enable_mask,
   input wire logic stamp_overwrite_enable,
   input wire logic order_log_overwrite_enable,
   input wire rols_ack_s acknowledge,
   input wire logic [CHANNELS-1:0] channel_stamp_bytes_read,
   input wire logic rd_en,
   input wire logic [7:0] rd_cmd,
   output logic [7:0] rd_data_r,
   output logic logging_running_r
);

   localparam logic [CHANNELS-1:0] ALL_ONES = '1;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; a level change counts once second and third stages agree
   logic [2:0] shdn_sync_r;
   logic [2:0] slp_sync_r;
   logic shdn_level_r;
   logic slp_level_r;
   logic shdn_rise;
   logic shdn_fall;
   logic slp_rise;
   logic slp_fall;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shdn_sync_r <= 3'h0;
         slp_sync_r <= 3'h0;
      end else begin
         shdn_sync_r <= {shdn_sync_r[1:0], shutdown_control_pin};
         slp_sync_r <= {slp_sync_r[1:0], sleep_control_pin};
      end
   end

   assign shdn_rise = shdn_sync_r[1] & shdn_sync_r[2] & ~shdn_level_r;
   assign shdn_fall = ~shdn_sync_r[1] & ~shdn_sync_r[2] & shdn_level_r;
   assign slp_rise = slp_sync_r[1] & slp_sync_r[2] & ~slp_level_r;
   assign slp_fall = ~slp_sync_r[1] & ~slp_sync_r[2] & slp_level_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shdn_level_r <= 1'b0;
         slp_level_r <= 1'b0;
      end else begin
         if (shdn_sync_r[1] == shdn_sync_r[2]) begin
            shdn_level_r <= shdn_sync_r[2];
         end
         if (slp_sync_r[1] == slp_sync_r[2]) begin
            slp_level_r <= slp_sync_r[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Recording control
   rols_kind_e kind_r;
   rols_kind_e kind_nxt;
   logic start;
   logic done;
   logic [CHANNELS-1:0] captured_r;
   logic [3:0] ready_r;
   logic stamp_ready_r;
   logic entry_write_ok;

   assign start = shdn_rise | shdn_fall | slp_rise | slp_fall | manual_log_trigger;
   assign done = logging_running_r & ~start & ((captured_r | ~channel_enable_mask) == ALL_ONES);
   // A full log only takes new entries when overwrite is on
   assign entry_write_ok = ~ready_r[kind_r] | order_log_overwrite_enable;

   always_comb begin
      kind_nxt = kind_r;
      if (shdn_rise) begin
         kind_nxt = rols_powerup;
      end else if (shdn_fall) begin
         kind_nxt = rols_powerdown;
      end else if (slp_rise) begin
         kind_nxt = rols_wake;
      end else if (slp_fall) begin
         kind_nxt = rols_doze;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         logging_running_r <= ROLS_FLAG_RESET;
         kind_r <= rols_powerup;
      end else begin
         if (start) begin
            logging_running_r <= 1'b1;
            kind_r <= kind_nxt;
         end else if (done) begin
            logging_running_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per channel capture of the sync edge counter
   logic [7:0] entry_r [4][CHANNELS];

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         logic capture;
         assign capture = logging_running_r & ~start & channel_crossed[ch] & ~captured_r[ch] &
                          channel_enable_mask[ch];

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               captured_r[ch] <= 1'b0;
            end else if (start) begin
               captured_r[ch] <= 1'b0;
            end else if (capture) begin
               captured_r[ch] <= 1'b1;
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               for (int k = 0; k < 4; k++) begin
                  entry_r[k][ch] <= ROLS_ENTRY_RESET;
               end
            end else if (capture && entry_write_ok) begin
               entry_r[kind_r][ch] <= sync_edge_counter;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Ready flags and their clearing
   logic [7:0] log_base [4];
   logic [3:0] ack_vec;
   logic [CHANNELS-1:0] seen_r [4];
   logic [CHANNELS-1:0] stamp_seen_r;
   logic stamp_clear;

   assign log_base[0] = ROLS_POWERUP_BASE;
   assign log_base[1] = ROLS_POWERDOWN_BASE;
   assign log_base[2] = ROLS_WAKE_BASE;
   assign log_base[3] = ROLS_DOZE_BASE;
   assign ack_vec = {acknowledge.doze, acknowledge.wake, acknowledge.powerdown,
                     acknowledge.powerup};

   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_log
         logic set;
         logic clear;
         logic [CHANNELS-1:0] hit;
         for (ch = 0; ch < CHANNELS; ch++) begin : g_hit
            assign hit[ch] = rd_en && (rd_cmd == log_base[k] + 8'(ch));
         end
         assign set = done && (kind_r == rols_kind_e'(k));
         assign clear = order_log_overwrite_enable ?
                        ((seen_r[k] | ~channel_enable_mask) == ALL_ONES) : ack_vec[k];

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ready_r[k] <= ROLS_FLAG_RESET;
               seen_r[k] <= '0;
            end else if (set) begin
               ready_r[k] <= 1'b1;
               seen_r[k] <= '0;
            end else if (ready_r[k] && clear) begin
               ready_r[k] <= 1'b0;
               seen_r[k] <= '0;
            end else begin
               seen_r[k] <= seen_r[k] | hit;
            end
         end
      end
   endgenerate

   assign stamp_clear = stamp_overwrite_enable ?
                        ((stamp_seen_r | ~channel_enable_mask) == ALL_ONES) : acknowledge.stamp;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stamp_ready_r <= ROLS_FLAG_RESET;
         stamp_seen_r <= '0;
      end else if (done) begin
         stamp_ready_r <= 1'b1;
         stamp_seen_r <= '0;
      end else if (stamp_ready_r && stamp_clear) begin
         stamp_ready_r <= 1'b0;
         stamp_seen_r <= '0;
      end else begin
         stamp_seen_r <= stamp_seen_r | channel_stamp_bytes_read;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port
   logic [7:0] rd_mux;
   logic [7:0] rec_status;
   logic [7:0] off_status;

   always_comb begin
      rec_status = 8'h00;
      rec_status[ROLS_ACTIVE_BIT] = logging_running_r;
      rec_status[ROLS_KIND_LSB +: 2] = kind_r;
      rec_status[ROLS_STAMP_BIT] = stamp_ready_r;
      rec_status[ROLS_POWERUP_BIT] = ready_r[0];
      rec_status[ROLS_POWERDOWN_BIT] = ready_r[1];
      rec_status[ROLS_WAKE_BIT] = ready_r[2];
      rec_status[ROLS_DOZE_BIT] = ready_r[3];
      off_status = 8'h00;
      off_status[CHANNELS-1:0] = channel_off;
   end

   always_comb begin
      rd_mux = ROLS_UNMAPPED_DATA;
      if (rd_cmd == ROLS_SELFTEST_ADDR) begin
         rd_mux[ROLS_SELFTEST_BIT] = analog_selftest_fail;
      end else if (rd_cmd == ROLS_OFF_ADDR) begin
         rd_mux = off_status;
      end else if (rd_cmd == ROLS_REC_ADDR) begin
         rd_mux = rec_status;
      end else begin
         for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < CHANNELS; j++) begin
               if (rd_cmd == log_base[i] + 8'(j)) begin
                  rd_mux = entry_r[i][j];
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= 8'h00;
      end else if (rd_en) begin
         rd_data_r <= rd_mux;
      end
   end

endmodule

// ### tb/rols_host.sv
// Host model: register reads, acknowledge writes and stamp reads.
// Assumes one-cycle strobes sampled on the rising clock edge.
module rols_host
   import rols_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] rd_data_r,
   output logic rd_en = 1'b0,
   output logic [7:0] rd_cmd = 8'h00,
   output rols_ack_s acknowledge = '0,
   output logic [5:0] stamp_rd = 6'h00
);
   timeunit 1ns / 1ps;
   task automatic read(input logic [7:0] c, output logic [7:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      rd_cmd <= c;
      @(posedge clk);
      rd_en <= 1'b0;
      rd_cmd <= ~c;
      #1 d = rd_data_r;
   endtask
   task automatic pulse(input rols_ack_s a, input logic [5:0] s);
      @(posedge clk);
      acknowledge <= a;
      stamp_rd <= s;
      @(posedge clk);
      acknowledge <= '0;
      stamp_rd <= 6'h00;
   endtask
endmodule

// ### tb/rols_status_props.sv
// Checker for the status block, bound to its ports.
// Assumes reads and manual starts are one-cycle pulses on clk.
module rols_status_props
   import rols_pkg::*;
#(parameter int CHANNELS = ROLS_CHANNELS) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic manual_log_trigger,
   input wire logic [CHANNELS-1:0] channel_crossed,
   input wire logic [CHANNELS-1:0] channel_off,
   input wire logic analog_selftest_fail,
   input wire logic [CHANNELS-1:0] channel_enable_mask,
   input wire logic rd_en,
   input wire logic [7:0] rd_cmd,
   input wire logic [7:0] rd_data_r,
   input wire logic logging_running_r
);
   timeunit 1ns / 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   sequence s_start;
      manual_log_trigger ##1 !manual_log_trigger;
   endsequence
   sequence s_capture;
      channel_crossed == channel_enable_mask && channel_enable_mask != '0 ##1 !manual_log_trigger;
   endsequence
   ////////////////////////////////////////////////////////////////
   a_selftest_read: assert property (
      rd_en && rd_cmd == ROLS_SELFTEST_ADDR |=> rd_data_r == 8'($past(analog_selftest_fail)))
      else $error("selftest read wrong");
   a_off_read: assert property (
      rd_en && rd_cmd == ROLS_OFF_ADDR |=> rd_data_r == 8'($past(channel_off)))
      else $error("off read wrong");
   a_running_read: assert property (
      rd_en && rd_cmd == ROLS_REC_ADDR |=> rd_data_r[7] == $past(logging_running_r))
      else $error("running bit wrong");
   a_manual_start: assert property (
      manual_log_trigger |=> logging_running_r) else $error("no start");
   a_reset_idle: assert property (
      $rose(rst_n) |-> !logging_running_r) else $error("running after reset");
   a_done_stop: assert property (
      s_start ##1 s_capture |=> !logging_running_r) else $error("no stop");
   a_unmapped_zero: assert property (
      rd_en && rd_cmd == 8'h33 |=> rd_data_r == ROLS_UNMAPPED_DATA) else $error("unmapped");
   a_data_hold: assert property (
      !rd_en |=> $stable(rd_data_r)) else $error("read data moved");
endmodule
bind rols_status rols_status_props #(.CHANNELS(CHANNELS)) u_props (.clk, .rst_n,
   .manual_log_trigger, .channel_crossed, .channel_off, .analog_selftest_fail,
   .channel_enable_mask, .rd_en, .rd_cmd, .rd_data_r, .logging_running_r);

// ### tb/rols_status_tb.sv
// Testbench for the status block with host model and bound checker.
// Assumes package, checker and host model are compiled first.
module rols_status_tb
   import rols_pkg::*;
;
   timeunit 1ns / 1ps;
   logic clk = 1'b0, rst_n = 1'b0, shut = 1'b0, sleep = 1'b0, trig = 1'b0;
   logic bist = 1'b0, sow = 1'b0, oow = 1'b0, rd_en, run;
   logic [5:0] crossed = 6'h00, off = 6'h00, mask = 6'h3f, stamp;
   logic [7:0] cnt = 8'h00, rd_cmd, rd_data, d;
   rols_ack_s ack;
   int fails = 0, checks = 0, seed = 98392, rdy = 0, kind = 0, k, i;
   always #5 clk = ~clk;
   rols_status #(.CHANNELS(6)) dut (.clk, .rst_n, .shutdown_control_pin(shut),
      .sleep_control_pin(sleep), .manual_log_trigger(trig), .channel_crossed(crossed),
      .sync_edge_counter(cnt), .channel_off(off), .analog_selftest_fail(bist),
      .channel_enable_mask(mask), .stamp_overwrite_enable(sow),
      .order_log_overwrite_enable(oow), .acknowledge(ack), .channel_stamp_bytes_read(stamp),
      .rd_en, .rd_cmd, .rd_data_r(rd_data), .logging_running_r(run));
   rols_host host (.clk, .rd_data_r(rd_data), .rd_en, .rd_cmd, .acknowledge(ack),
      .stamp_rd(stamp));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stat(input int r);
      host.read(ROLS_REC_ADDR, d);
      chk("status", d, {1'(r), 2'(kind), 5'(rdy)});
      chk("running", {7'h00, run}, 8'(r));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      fails++;
      finish_test;
   end
   initial begin
      cyc(2);
      rst_n <= 1'b1;
      stat(0);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         bist <= 1'($random(seed));
         off <= 6'($random(seed));
         host.read(ROLS_SELFTEST_ADDR, d);
         chk("selftest", d, {7'h00, bist});
         host.read(ROLS_OFF_ADDR, d);
         chk("off", d, {2'h0, off});
      end
      host.read(8'h33, d);
      chk("unmapped", d, ROLS_UNMAPPED_DATA);
      $display("test done: static reads");
      for (k = 0; k < 4; k++) begin
         @(posedge clk);
         mask <= 6'($random(seed)) | 6'h01;
         cnt <= 8'($random(seed));
         sow <= k[0];
         oow <= k[0];
         if (k < 2) shut <= ~shut;
         else sleep <= ~sleep;
         kind = k;
         cyc(6);
         stat(1);
         @(posedge clk);
         crossed <= 6'h3f;
         @(posedge clk);
         crossed <= 6'h00;
         cyc(3);
         rdy = rdy | 16 | (8 >> k);
         stat(0);
         for (i = 0; i < 6; i++) begin
            host.read(ROLS_POWERUP_BASE + 8'(16 * k + i), d);
            chk("entry", d, mask[i] ? cnt : ROLS_ENTRY_RESET);
         end
         host.pulse('0, mask);
         cyc(2);
         if (k[0]) rdy = 0;
         stat(0);
         if (!k[0]) begin
            host.pulse(5'h1f, 6'h00);
            cyc(2);
            rdy = 0;
            stat(0);
         end
         $display("test done: kind %0d", k);
      end
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      @(posedge clk);
      crossed <= mask;
      @(posedge clk);
      crossed <= 6'h00;
      cyc(3);
      rdy = 17;
      stat(0);
      $display("test done: manual start");
      @(posedge clk);
      oow <= 1'b0;
      cnt <= cnt + 8'h01;
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      @(posedge clk);
      crossed <= mask;
      @(posedge clk);
      crossed <= 6'h00;
      cyc(3);
      stat(0);
      for (i = 0; i < 6; i++) begin
         host.read(ROLS_DOZE_BASE + 8'(i), d);
         chk("kept", d, mask[i] ? cnt - 8'h01 : ROLS_ENTRY_RESET);
      end
      $display("test done: full log kept");
      finish_test;
   end
endmodule
